// File: wdp_pkg.sv
// constants shared by the watchdog and periodic interrupt block
package wdp_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ     = 200_000_000;
  localparam int unsigned DOG_CLK_HZ      = 16_384;
  // one dog clock period in core cycles, rounded down
  localparam int unsigned DOG_TICK_CYCLES = CORE_CLK_HZ / DOG_CLK_HZ;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PERIODIC_COUNTER = 16'h7021;
  localparam logic [15:0] ADDR_DOG_COUNTER      = 16'h7023;
  localparam logic [15:0] ADDR_DOG_KEY          = 16'h7025;
  localparam logic [15:0] ADDR_PERIODIC_CTRL    = 16'h7027;
  localparam logic [15:0] ADDR_DOG_CTRL         = 16'h7029;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_FLAG      = 7;
  localparam int unsigned BIT_ENABLE    = 6;
  localparam int unsigned BIT_DISABLE   = 6;
  localparam int unsigned CHECK_HI      = 5;
  localparam int unsigned CHECK_LO      = 3;
  localparam int unsigned SEL_HI        = 2;
  localparam logic [2:0]  CHECK_PATTERN = 3'h5;

  // ----------------------------------------------------------------
  // key values and counter geometry
  // ----------------------------------------------------------------
  localparam logic [7:0]  KEY_ARM       = 8'h55;
  localparam logic [7:0]  KEY_SERVICE   = 8'hAA;
  localparam int unsigned PRESCALE_W    = 7;
  localparam int unsigned PCOUNT_W      = 8;
  localparam int unsigned CHAIN_W       = PRESCALE_W + PCOUNT_W;
  localparam logic [7:0]  RESET_VALUE   = 8'h00;

  // periodic taps as log2 of the dog clock divider: 4 .. 16384
  localparam logic [3:0] PTAP_LOG2 [8] = '{4'h2, 4'h4, 4'h6, 4'h7,
                                           4'h8, 4'h9, 4'hB, 4'hE};
  // watchdog taps as log2 of the divider: 1,1,2,4 .. 64
  localparam logic [3:0] DTAP_LOG2 [8] = '{4'h0, 4'h0, 4'h1, 4'h2,
                                           4'h3, 4'h4, 4'h5, 4'h6};

endpackage : wdp_pkg

// File: wdp_prescaler.sv
// dog clock enable divider and free-running prescaler
`timescale 1ns/1ps
module wdp_prescaler #(
  parameter int unsigned TICK_CYCLES = wdp_pkg::DOG_TICK_CYCLES
) (
  // clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  // dog clock enable and prescaler value
  output logic                               dog_tick,
  output logic [wdp_pkg::PRESCALE_W-1:0]     prescale
);

  // ----------------------------------------------------------------
  // dog clock divider
  // ----------------------------------------------------------------
  logic [15:0] div_count;
  wire         div_wrap = (div_count == 16'(TICK_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      div_count <= 16'h0000;
      dog_tick  <= 1'b0;
    end else begin
      div_count <= div_wrap ? 16'h0000 : div_count + 16'h0001;
      dog_tick  <= div_wrap;
    end
  end

  // ----------------------------------------------------------------
  // prescaler: never cleared by software, only by reset
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prescale <= '0;
    end else if (dog_tick) begin
      prescale <= prescale + 1'b1;
    end
  end

endmodule : wdp_prescaler

// File: wdp_watchdog.sv
// watchdog timer and periodic interrupt control, top level
// Operation
// - overflow sets periodic flag; writing 0 clears
// - flag clear unneeded; setting flag never interrupts
// - enabled: request interrupt on each tap overflow
// - enable write 0 cancels pending, blocks future
// - exactly one request per overflow leading edge
// - taps from prescaler, slow ones via counter
// - periodic control bits 5-3 ignore writes, read 0
// - periodic select picks divider 4 .. 16384
// - nominal dog clock gives 244us to 1s
// - control writes need 101 check, else reset
// - watchdog check bits always read zero
// - flag set only by watchdog-caused reset
// - disable bit works only while unlock set
// - watchdog select picks divider 1 .. 64
// - 257 tap clocks before overflow reset
// - prescaler not cleared, timeout up to 1/256 longer
// - timeouts 15.63 ms up to 1.0 s
// - 55h then AAh clears counter; others reset
// - one extra tap clock after overflow, then reset
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module wdp_watchdog #(
  parameter int unsigned TICK_CYCLES = wdp_pkg::DOG_TICK_CYCLES
) (
  // clock and resets
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        pwr_on_rstn,
  // register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rd_data,
  // system control
  input  wire logic        high_supply_unlock,
  input  wire logic        periodic_irq_ack,
  output logic             periodic_irq_req,
  output logic             dog_sys_reset
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                              dog_tick;
  logic [wdp_pkg::PRESCALE_W-1:0]    prescale;
  logic [wdp_pkg::PCOUNT_W-1:0]      periodic_counter;
  logic                              periodic_overflow_flag;
  logic                              periodic_irq_enable;
  logic [2:0]                        periodic_tap_select;
  logic [7:0]                        dog_counter;
  logic                              dog_ovf_pending;
  logic                              dog_key_armed;
  logic                              dog_reset_flag;
  logic                              dog_disable;
  logic [2:0]                        dog_tap_select;

  // tick period fixes the nominal dog clock
  wdp_prescaler #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_prescaler (
    .core_clk (core_clk),
    .rstn     (rstn),
    .dog_tick (dog_tick),
    .prescale (prescale)
  );

  // ----------------------------------------------------------------
  // tap decoding
  // ----------------------------------------------------------------
  // true when the low 'width' bits of the chain are all ones
  function automatic logic low_ones(input logic [wdp_pkg::CHAIN_W-1:0] chain,
                                    input logic [3:0] width);
    logic [wdp_pkg::CHAIN_W-1:0] mask;
    mask = ~({wdp_pkg::CHAIN_W{1'b1}} << width);
    return &(chain | ~mask);
  endfunction : low_ones

  wire [wdp_pkg::CHAIN_W-1:0] chain = {periodic_counter, prescale};

  wire [3:0] ptap_w = wdp_pkg::PTAP_LOG2[periodic_tap_select];
  // watchdog divider select, low bit ignored for 00x
  wire [3:0] dtap_w = wdp_pkg::DTAP_LOG2[dog_tap_select];

  // slow taps reach into the periodic counter bits
  // the chain wraps once per period, so one event each
  wire periodic_evt  = dog_tick & low_ones(chain, ptap_w);
  // tap phase follows the free prescaler, not the service
  wire dog_tap       = dog_tick & low_ones(chain, dtap_w);
  wire pcount_step   = dog_tick & (&prescale);

  // disable honoured only with the unlock level
  wire dog_running   = ~(dog_disable & high_supply_unlock);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire wr_pcount  = wr_en & (addr == wdp_pkg::ADDR_PERIODIC_COUNTER);
  wire wr_key     = wr_en & (addr == wdp_pkg::ADDR_DOG_KEY);
  wire wr_pctrl   = wr_en & (addr == wdp_pkg::ADDR_PERIODIC_CTRL);
  wire wr_dctrl   = wr_en & (addr == wdp_pkg::ADDR_DOG_CTRL);

  wire [2:0] wr_check   = wr_data[wdp_pkg::CHECK_HI:wdp_pkg::CHECK_LO];
  wire       check_ok   = (wr_check == wdp_pkg::CHECK_PATTERN);
  wire       dctrl_ok   = wr_dctrl & check_ok;
  wire       dctrl_bad  = wr_dctrl & ~check_ok;

  wire key_arm      = wr_key & (wr_data == wdp_pkg::KEY_ARM);
  wire key_service  = wr_key & (wr_data == wdp_pkg::KEY_SERVICE);
  wire key_bad      = wr_key & ~key_arm & ~key_service;
  wire dog_kick     = key_service & dog_key_armed;

  // check bits are never stored, so they read as zero
  wire [7:0] dctrl_view = {dog_reset_flag, dog_disable, 3'b000, dog_tap_select};
  // reserved periodic bits read as zero
  wire [7:0] pctrl_view = {periodic_overflow_flag, periodic_irq_enable,
                           3'b000, periodic_tap_select};

  wire [7:0] next_rd_data =
    (addr == wdp_pkg::ADDR_PERIODIC_COUNTER) ? periodic_counter :
    (addr == wdp_pkg::ADDR_DOG_COUNTER)      ? dog_counter      :
    (addr == wdp_pkg::ADDR_DOG_KEY)          ? dctrl_view       :
    (addr == wdp_pkg::ADDR_PERIODIC_CTRL)    ? pctrl_view       :
    (addr == wdp_pkg::ADDR_DOG_CTRL)         ? dctrl_view       : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_data <= wdp_pkg::RESET_VALUE;
    end else begin
      rd_data <= rd_en ? next_rd_data : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // periodic counter and control
  // ----------------------------------------------------------------
  // any write clears the counter; the prescaler keeps running
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      periodic_counter <= '0;
    end else if (wr_pcount) begin
      periodic_counter <= '0;
    end else if (pcount_step) begin
      periodic_counter <= periodic_counter + 1'b1;
    end
  end

  // hardware set wins over a software clear
  wire next_pflag = periodic_evt
                  | (wr_pctrl ? wr_data[wdp_pkg::BIT_FLAG] : periodic_overflow_flag);
  wire next_pen   = wr_pctrl ? wr_data[wdp_pkg::BIT_ENABLE] : periodic_irq_enable;

  // bits 5-3 of the write are dropped
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      periodic_overflow_flag <= 1'b0;
      periodic_irq_enable    <= 1'b0;
      periodic_tap_select    <= 3'b000;
    end else begin
      periodic_overflow_flag <= next_pflag;
      periodic_irq_enable    <= next_pen;
      if (wr_pctrl) begin
        periodic_tap_select <= wr_data[wdp_pkg::SEL_HI:0];
      end
    end
  end

  // request on the overflow event, driven by the event alone
  // the flag bit itself never feeds the request
  // enable written 0 cancels and blocks
  wire next_irq = next_pen & (periodic_evt | (periodic_irq_req & ~periodic_irq_ack));

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      periodic_irq_req <= 1'b0;
    end else begin
      periodic_irq_req <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter and key
  // ----------------------------------------------------------------
  // 256 taps to wrap, one more tap with the wrap pending
  // the extra tap gives software a last service window
  wire ovf_fire    = dog_running & dog_tap & dog_ovf_pending & ~dog_kick;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dog_counter     <= 8'h00;
      dog_ovf_pending <= 1'b0;
    end else if (dog_kick) begin
      // 55h then AAh services the counter
      dog_counter     <= 8'h00;
      dog_ovf_pending <= 1'b0;
    end else if (dog_running & dog_tap & ~dog_ovf_pending) begin
      dog_counter     <= dog_counter + 8'h01;
      dog_ovf_pending <= (dog_counter == 8'hFF);
    end
  end

  // 55h may repeat; AAh without the arm is harmless
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dog_key_armed <= 1'b0;
    end else if (key_arm) begin
      dog_key_armed <= 1'b1;
    end else if (key_service | key_bad) begin
      dog_key_armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // watchdog control and reset request
  // ----------------------------------------------------------------
  // bad check pattern and bad key both reset
  wire next_sys_reset = dctrl_bad | key_bad | ovf_fire;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dog_sys_reset <= 1'b0;
    end else begin
      dog_sys_reset <= next_sys_reset;
    end
  end

  // a bad write changes no field
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dog_disable    <= 1'b0;
      dog_tap_select <= 3'b000;
    end else if (dctrl_ok) begin
      dog_disable    <= wr_data[wdp_pkg::BIT_DISABLE];
      dog_tap_select <= wr_data[wdp_pkg::SEL_HI:0];
    end
  end

  // survives system reset, reset only at power-on
  // valid write of 0 clears, the watchdog set wins
  wire next_dflag = dog_sys_reset
                  | (dog_reset_flag & ~(dctrl_ok & ~wr_data[wdp_pkg::BIT_FLAG]));

  always_ff @(posedge core_clk) begin
    if (!pwr_on_rstn) begin
      dog_reset_flag <= 1'b0;
    end else begin
      dog_reset_flag <= next_dflag;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_PFLAG_SET: assert property (@(posedge core_clk) disable iff (!rstn)
    periodic_evt |=> periodic_overflow_flag)
    else $error("overflow did not set the periodic flag");

  AST_SW_SET_NO_IRQ: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_pctrl && wr_data[7] && !periodic_evt && !periodic_irq_req |=> !periodic_irq_req)
    else $error("software flag set raised an interrupt");

  AST_IRQ_ON_EVT: assert property (@(posedge core_clk) disable iff (!rstn)
    periodic_evt && next_pen |=> periodic_irq_req)
    else $error("enabled overflow gave no interrupt request");

  AST_DISABLE_CANCEL: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_pctrl && !wr_data[6] |=> !periodic_irq_req ##1 !periodic_irq_req)
    else $error("disabled periodic interrupt still pending");

  AST_ONE_PER_EVT: assert property (@(posedge core_clk) disable iff (!rstn)
    periodic_evt |=> !periodic_evt [*8])
    else $error("two overflow events too close together");

  AST_PRSV_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_en && addr == wdp_pkg::ADDR_PERIODIC_CTRL |=> rd_data[5:3] == 3'b000)
    else $error("reserved periodic bits read non-zero");

  AST_CHECK_RESET: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_dctrl && wr_data[5:3] != 3'b101 |=> dog_sys_reset)
    else $error("bad check pattern did not reset");

  AST_CHECK_READ_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_en && addr == wdp_pkg::ADDR_DOG_CTRL |=> rd_data[5:3] == 3'b000)
    else $error("check bits read non-zero");

  AST_FLAG_ON_RESET: assert property (@(posedge core_clk) disable iff (!pwr_on_rstn)
    dog_sys_reset |=> dog_reset_flag)
    else $error("watchdog reset did not set the flag");

  AST_DISABLED_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_disable && high_supply_unlock && !wr_en |=> $stable(dog_counter))
    else $error("disabled watchdog kept counting");

  AST_WRAP_PENDING: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_running && dog_tap && dog_counter == 8'hFF && !dog_ovf_pending && !dog_kick
    |=> dog_ovf_pending && dog_counter == 8'h00)
    else $error("counter wrap did not arm the overflow");

  AST_KEY_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_key_armed && key_service |=> dog_counter == 8'h00 && !dog_ovf_pending)
    else $error("key sequence did not clear the counter");

  AST_EXTRA_TAP: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_ovf_pending && dog_running && dog_tap && !dog_kick |=> dog_sys_reset)
    else $error("pending overflow did not reset on the next tap");

  AST_ACK_DROP: assert property (@(posedge core_clk) disable iff (!rstn)
    periodic_irq_req && periodic_irq_ack && !periodic_evt |=> !periodic_irq_req)
    else $error("acknowledged request did not drop");

  AST_PEN_BLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
    !periodic_irq_enable && !wr_pctrl |=> !periodic_irq_req)
    else $error("request raised while periodic interrupt disabled");

  AST_PTAP_SEL: assert property (@(posedge core_clk) disable iff (!rstn)
    periodic_evt |-> (periodic_tap_select != 3'b000 || &prescale[1:0])
                  && (periodic_tap_select != 3'b111 || &{periodic_counter[6:0], prescale}))
    else $error("periodic event off its selected divider");

  AST_DTAP_FAST: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_tick && dog_tap_select[2:1] == 2'b00 |-> dog_tap)
    else $error("divider one did not tap on every dog tick");

  AST_DTAP_SLOW: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_tap && dog_tap_select == 3'b111 |-> &prescale[5:0])
    else $error("divider 64 tapped off its phase");

  AST_PRESCALE_FREE: assert property (@(posedge core_clk) disable iff (!rstn)
    dog_tick |=> prescale == $past(prescale) + 7'h01)
    else $error("prescaler did not run freely");

  AST_BAD_WRITE_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_en && addr == wdp_pkg::ADDR_DOG_CTRL && wr_data[5:3] != 3'b101
    |=> $stable(dog_disable) && $stable(dog_tap_select))
    else $error("bad check pattern changed a control field");

  AST_KEY_BAD_RESET: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_en && addr == wdp_pkg::ADDR_DOG_KEY && wr_data != 8'h55 && wr_data != 8'hAA
    |=> dog_sys_reset)
    else $error("bad key did not reset");

  AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (!pwr_on_rstn)
    dog_reset_flag && !(wr_en && addr == wdp_pkg::ADDR_DOG_CTRL) |=> dog_reset_flag)
    else $error("watchdog flag lost without a clearing write");

  AST_FLAG_CLEAR: assert property (@(posedge core_clk) disable iff (!pwr_on_rstn)
    wr_en && addr == wdp_pkg::ADDR_DOG_CTRL && wr_data[5:3] == 3'b101 && !wr_data[7]
    && !dog_sys_reset |=> !dog_reset_flag)
    else $error("valid write of zero did not clear the watchdog flag");

endmodule : wdp_watchdog

// File: wdp_watchdog_tb.sv
// self-checking bench for the watchdog and periodic interrupt block
`timescale 1ns/1ps
module wdp_watchdog_tb;

  // ----------------------------------------------------------------
  // parameters and signals
  // ----------------------------------------------------------------
  // short dog tick keeps the slow taps inside the run budget
  localparam int unsigned TICK      = 4;
  localparam int unsigned MAX_CYCLE = 80000;

  typedef struct {
    logic [15:0] wa;
    logic [7:0]  wd;
    logic [15:0] ra;
    logic [7:0]  exp;
  } wdp_row_t;

  logic        core_clk;
  logic        rstn;
  logic        pwr_on_rstn;
  logic [15:0] addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  rd_data;
  logic        high_supply_unlock;
  logic        periodic_irq_ack;
  logic        periodic_irq_req;
  logic        dog_sys_reset;
  int          bad_count;
  int          n_checks;
  int          cyc;
  int          n_dog;
  int          t0;
  int          c;
  int          n0;
  logic [7:0]  v;
  int unsigned pdiv [7] = '{4, 16, 64, 128, 256, 512, 2048};
  wdp_row_t    rows [6] = '{
    '{wdp_pkg::ADDR_DOG_CTRL,      8'h6F, wdp_pkg::ADDR_DOG_KEY,      8'h47},
    '{wdp_pkg::ADDR_PERIODIC_CTRL, 8'hFF, wdp_pkg::ADDR_PERIODIC_CTRL, 8'hC7},
    '{wdp_pkg::ADDR_PERIODIC_CTRL, 8'h38, wdp_pkg::ADDR_PERIODIC_CTRL, 8'h00},
    '{wdp_pkg::ADDR_DOG_CTRL,      8'hED, wdp_pkg::ADDR_DOG_CTRL,      8'h45},
    '{16'h702F,                    8'h5A, 16'h702F,                    8'h00},
    '{wdp_pkg::ADDR_DOG_COUNTER,   8'h77, wdp_pkg::ADDR_DOG_CTRL,      8'h45}};

  wdp_watchdog #(.TICK_CYCLES(TICK)) u_wdp_watchdog (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .pwr_on_rstn        (pwr_on_rstn),
    .addr               (addr),
    .wr_data            (wr_data),
    .wr_en              (wr_en),
    .rd_en              (rd_en),
    .rd_data            (rd_data),
    .high_supply_unlock (high_supply_unlock),
    .periodic_irq_ack   (periodic_irq_ack),
    .periodic_irq_req   (periodic_irq_req),
    .dog_sys_reset      (dog_sys_reset)
  );

  // ----------------------------------------------------------------
  // clock, cycle count, watchdog reset monitor
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (dog_sys_reset === 1'b1) begin
      n_dog <= n_dog + 1;
    end
    if (cyc >= MAX_CYCLE) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en   <= 1'b0;
    #1;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : bus_rd

  task automatic ack_req();
    periodic_irq_ack <= 1'b1;
    @(posedge core_clk);
    periodic_irq_ack <= 1'b0;
    #1;
  endtask : ack_req

  task automatic wait_req(input int lim, output int n);
    n = 0;
    while (periodic_irq_req !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      #1;
      n = n + 1;
    end
  endtask : wait_req

  task automatic kick();
    bus_wr(wdp_pkg::ADDR_DOG_KEY, 8'h55);
    bus_wr(wdp_pkg::ADDR_DOG_KEY, 8'hAA);
  endtask : kick

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    n_dog = 0;
    rstn = 1'b0;
    pwr_on_rstn = 1'b0;
    addr = 16'h0000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    high_supply_unlock = 1'b0;
    periodic_irq_ack = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    pwr_on_rstn <= 1'b1;
    t0 = cyc;
    #1;
    bus_rd(wdp_pkg::ADDR_PERIODIC_CTRL, v);
    check("periodic ctrl reset", 8'h00, v);
    bus_rd(wdp_pkg::ADDR_DOG_CTRL, v);
    check("dog ctrl reset", 8'h00, v);
    @(posedge core_clk);
    #1;
    check("idle rd_data", 8'h00, rd_data);
    // unserviced counter overflows after 256 taps and resets on one more tap, 257 in all
    wait (dog_sys_reset === 1'b1);
    c = cyc - t0;
    check("dog timeout window", 1, (c >= 257 * TICK - 2) && (c <= 258 * TICK + 3));
    @(posedge core_clk);
    #1;
    check("reset pulse width", 1'b0, dog_sys_reset);
    // system reset only: flag survives
    rstn <= 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    bus_rd(wdp_pkg::ADDR_DOG_CTRL, v);
    check("flag after dog reset", 8'h80, v);
    bus_wr(wdp_pkg::ADDR_DOG_CTRL, 8'h28);
    bus_rd(wdp_pkg::ADDR_DOG_CTRL, v);
    check("flag cleared", 8'h00, v);
    high_supply_unlock <= 1'b1;
    n0 = n_dog;
    // ----------------------------------------------------------------
    // register rows
    // ----------------------------------------------------------------
    foreach (rows[i]) begin
      bus_wr(rows[i].wa, rows[i].wd);
      bus_rd(rows[i].ra, v);
      check("row read", rows[i].exp, v);
      check("row req", 1'b0, periodic_irq_req);
    end
    // ----------------------------------------------------------------
    // periodic taps: measure the interval from the second to the third request
    // ----------------------------------------------------------------
    foreach (pdiv[s]) begin
      bus_wr(wdp_pkg::ADDR_PERIODIC_CTRL, {5'b01000, 3'(s)});
      wait_req(20000, c);
      ack_req();
      wait_req(20000, c);
      t0 = cyc;
      if (s == 0) begin
        bus_rd(wdp_pkg::ADDR_PERIODIC_CTRL, v);
        check("flag set by overflow", 8'hC0, v);
        wait_req(100, c);
      end
      ack_req();
      check("req dropped by ack", 1'b0, periodic_irq_req);
      wait_req(20000, c);
      check("periodic interval", TICK * pdiv[s], cyc - t0);
    end
    bus_wr(wdp_pkg::ADDR_PERIODIC_CTRL, 8'h00);
    check("req cancelled", 1'b0, periodic_irq_req);
    c = 0;
    repeat (64) begin
      @(posedge core_clk);
      #1;
      c = c + ((periodic_irq_req !== 1'b0) ? 1 : 0);
    end
    check("no req while disabled", 0, c);
    check("disabled dog silent", n0, n_dog);
    // ----------------------------------------------------------------
    // watchdog keys and check bits
    // ----------------------------------------------------------------
    // disable is ignored without the unlock, so kicks must keep it quiet
    high_supply_unlock <= 1'b0;
    bus_wr(wdp_pkg::ADDR_DOG_CTRL, 8'h68);
    repeat (4) begin
      repeat (150 * TICK) @(posedge core_clk);
      bus_wr(wdp_pkg::ADDR_DOG_KEY, 8'h55);
      kick();
      bus_rd(wdp_pkg::ADDR_DOG_COUNTER, v);
      check("counter after kick", 1, v <= 8'h01);
    end
    check("kicked dog silent", n0, n_dog);
    bus_wr(wdp_pkg::ADDR_DOG_KEY, 8'hAA);
    @(posedge core_clk);
    #1;
    check("lone second key", n0, n_dog);
    bus_wr(wdp_pkg::ADDR_DOG_KEY, 8'h12);
    check("bad key reset", 1'b1, dog_sys_reset);
    @(posedge core_clk);
    #1;
    check("bad key pulse width", 1'b0, dog_sys_reset);
    bus_wr(wdp_pkg::ADDR_DOG_CTRL, 8'h0F);
    check("bad check reset", 1'b1, dog_sys_reset);
    @(posedge core_clk);
    #1;
    bus_rd(wdp_pkg::ADDR_DOG_CTRL, v);
    check("ctrl after bad check", 8'h80, v & 8'hBF);
    stop_test();
  end

endmodule : wdp_watchdog_tb
